/* common/pds_pkg.sv */
// Package for the phase-step handshake: counter select codes, tap widths, timing.
// Assumes both ends and the interface are compiled after it.
package pds_pkg;
    localparam int SEL_W = 3;
    localparam int TAP_W = 3;
    localparam int NUM_OUT = 5;
    localparam logic [SEL_W-1:0] SEL_ALL = 3'h0;
    localparam logic [SEL_W-1:0] SEL_FB = 3'h1;
    localparam logic [SEL_W-1:0] SEL_OUT0 = 3'h2;
    localparam logic [SEL_W-1:0] SEL_OUT4 = 3'h6;
    localparam logic [TAP_W-1:0] TAP_RST = 3'h0;
    localparam logic [TAP_W-1:0] TAP_ONE = 3'h1;
    localparam logic [3:0] SHIFT_CYC = 4'h3;
    localparam int VCO_DIV = 4;
    localparam logic [2:0] SCLK_HALF = 3'h2;
    typedef enum logic [1:0] {
        PDS_IDLE = 2'h0,
        PDS_WAIT = 2'h1,
        PDS_REL = 2'h3,
        PDS_DONE = 2'h2
    } pds_ctl_state_t;
endpackage

/* common/pds_if.sv */
// Interface joining the phase-step controller and the PLL phase-shift circuit.
// Assumes the controller drives scan_clk and stays free running.
`timescale 1ns/1ns
interface pds_if;
    logic scan_clk;
    logic [pds_pkg::SEL_W-1:0] counter_sel;
    logic step_up;
    logic step_req;
    logic step_done;
    modport dev (input scan_clk, input counter_sel, input step_up, input step_req,
                 output step_done);
    modport ctl (output scan_clk, output counter_sel, output step_up, output step_req,
                 input step_done);
endinterface

/* hdl/pds_device.sv */
// PLL phase-step circuit: scan-clock front end plus VCO-domain tap shifter.
// Assumes clk is the VCO-side clock and scan_clk runs free from the controller.
`timescale 1ns/1ns
module pds_device (
    pds_if.dev link,
    input wire logic clk,
    input wire logic srst,
    output logic [pds_pkg::TAP_W-1:0] fb_tap,
    output logic [pds_pkg::NUM_OUT*pds_pkg::TAP_W-1:0] out_tap,
    output logic [pds_pkg::NUM_OUT:0] vco_tick
);
    // Scan-clock domain
    logic req_neg_ff, nxt_req_neg;
    logic req_prev_ff, nxt_req_prev;
    logic [1:0] rise_cnt_ff, nxt_rise_cnt;
    logic [pds_pkg::SEL_W-1:0] sel_ff, nxt_sel;
    logic up_ff, nxt_up;
    logic go_tgl_ff, nxt_go_tgl;
    logic busy_ff, nxt_busy;
    logic [1:0] ack_sync_ff;
    logic done_clr;
    // VCO domain
    logic [1:0] go_sync_ff;
    logic go_seen_ff, nxt_go_seen;
    logic [3:0] sh_cnt_ff, nxt_sh_cnt;
    logic ack_tgl_ff, nxt_ack_tgl;
    logic [pds_pkg::TAP_W-1:0] tap_ff [pds_pkg::NUM_OUT+1];
    logic [pds_pkg::TAP_W-1:0] nxt_tap [pds_pkg::NUM_OUT+1];
    logic [pds_pkg::NUM_OUT:0] tick_ff, nxt_tick;
    logic [pds_pkg::SEL_W-1:0] vsel_ff, nxt_vsel;
    logic vup_ff, nxt_vup;
    // Reset synchronisers and decoded mask
    logic [1:0] srst_s_ff, nxt_srst_s;
    logic [1:0] srst_v_ff, nxt_srst_v;
    logic srst_s;
    logic srst_v;
    logic [pds_pkg::NUM_OUT:0] v_mask;

    // Slot 0 is feedback, slots 1..5 output counters; 111 selects nothing
    function automatic logic [pds_pkg::NUM_OUT:0] sel_mask(input logic [pds_pkg::SEL_W-1:0] s);
        logic [pds_pkg::NUM_OUT:0] m;
        m = '0;
        if (s == pds_pkg::SEL_ALL) begin
            m = {{pds_pkg::NUM_OUT{1'b1}}, 1'b0};
        end else if (s == pds_pkg::SEL_FB) begin
            m[0] = 1'b1;
        end else if (s >= pds_pkg::SEL_OUT0 && s <= pds_pkg::SEL_OUT4) begin
            m[s - pds_pkg::SEL_OUT0 + 3'h1] = 1'b1;
        end
        return m;
    endfunction

    // Reset arrives on the bench clock; two flops per domain before use
    always_comb begin
        nxt_srst_s = {srst_s_ff[0], srst};
    end
    always_ff @(posedge link.scan_clk) begin
        srst_s_ff <= nxt_srst_s;
    end
    assign srst_s = srst_s_ff[1];

    always_comb begin
        nxt_srst_v = {srst_v_ff[0], srst};
    end
    always_ff @(posedge clk) begin
        srst_v_ff <= nxt_srst_v;
    end
    assign srst_v = srst_v_ff[1];

    // Mask from the VCO-side copy, never from the scan side
    assign v_mask = sel_mask(vsel_ff);

    // Falling-edge capture of the request
    always_comb begin
        nxt_req_neg = srst_s ? 1'b0 : link.step_req;
    end
    always_ff @(negedge link.scan_clk) begin
        req_neg_ff <= nxt_req_neg;
    end

    // Busy ends once the VCO side has echoed this toggle
    assign done_clr = busy_ff && (ack_sync_ff[1] == go_tgl_ff);

    always_comb begin
        nxt_req_prev = req_neg_ff;
        nxt_rise_cnt = rise_cnt_ff;
        nxt_sel = sel_ff;
        nxt_up = up_ff;
        nxt_go_tgl = go_tgl_ff;
        nxt_busy = busy_ff;
        // New captured pulse arms the edge counter, one step per pulse
        if (req_neg_ff && !req_prev_ff && !busy_ff && rise_cnt_ff == 2'h0) begin
            nxt_rise_cnt = 2'h1;
        end else if (rise_cnt_ff == 2'h1) begin
            nxt_rise_cnt = 2'h2;
        end
        if (rise_cnt_ff == 2'h1) begin
            nxt_sel = link.counter_sel;
            nxt_up = link.step_up;
            nxt_go_tgl = ~go_tgl_ff;
            nxt_busy = 1'b1;
            nxt_rise_cnt = 2'h0;
        end else if (done_clr) begin
            nxt_busy = 1'b0;
        end
        if (srst_s) begin
            nxt_req_prev = 1'b0;
            nxt_rise_cnt = 2'h0;
            nxt_sel = pds_pkg::SEL_ALL;
            nxt_up = 1'b0;
            nxt_go_tgl = 1'b0;
            nxt_busy = 1'b0;
        end
    end
    always_ff @(posedge link.scan_clk) begin
        req_prev_ff <= nxt_req_prev;
        rise_cnt_ff <= nxt_rise_cnt;
        sel_ff <= nxt_sel;
        up_ff <= nxt_up;
        go_tgl_ff <= nxt_go_tgl;
        busy_ff <= nxt_busy;
        ack_sync_ff <= {ack_sync_ff[0], ack_tgl_ff};
    end

    // Done falls with the latching edge, rises once the VCO side acknowledges
    assign link.step_done = ~busy_ff;

    // VCO domain: sel and up are stable while busy, so sampling them after the
    // synchronised toggle is safe
    always_comb begin
        nxt_go_seen = go_sync_ff[1];
        nxt_sh_cnt = sh_cnt_ff;
        nxt_ack_tgl = ack_tgl_ff;
        nxt_vsel = vsel_ff;
        nxt_vup = vup_ff;
        for (int i = 0; i <= pds_pkg::NUM_OUT; i++) begin
            nxt_tap[i] = tap_ff[i];
            nxt_tick[i] = ~tick_ff[i];
        end
        if (go_sync_ff[1] != go_seen_ff) begin
            nxt_vsel = sel_ff;
            nxt_vup = up_ff;
            nxt_sh_cnt = pds_pkg::SHIFT_CYC;
        end else if (sh_cnt_ff != 4'h0) begin
            nxt_sh_cnt = sh_cnt_ff - 4'h1;
            if (sh_cnt_ff == 4'h1) begin
                // Select 111 gives an empty mask, so nothing moves
                for (int i = 0; i <= pds_pkg::NUM_OUT; i++) begin
                    if (v_mask[i]) begin
                        nxt_tap[i] = vup_ff ? tap_ff[i] + pds_pkg::TAP_ONE
                                            : tap_ff[i] - pds_pkg::TAP_ONE;
                    end
                end
                nxt_ack_tgl = ~ack_tgl_ff;
            end
        end
        if (srst_v) begin
            nxt_sh_cnt = 4'h0;
            nxt_vsel = pds_pkg::SEL_ALL;
            nxt_vup = 1'b0;
            nxt_go_seen = 1'b0;
            nxt_ack_tgl = 1'b0;
            for (int i = 0; i <= pds_pkg::NUM_OUT; i++) begin
                nxt_tap[i] = pds_pkg::TAP_RST;
                nxt_tick[i] = 1'b0;
            end
        end
    end
    // Ticks restart from zero with the taps, so reset is visible on them
    always_ff @(posedge clk) begin
        go_sync_ff <= {go_sync_ff[0], go_tgl_ff};
        go_seen_ff <= nxt_go_seen;
        sh_cnt_ff <= nxt_sh_cnt;
        ack_tgl_ff <= nxt_ack_tgl;
        vsel_ff <= nxt_vsel;
        vup_ff <= nxt_vup;
        tap_ff <= nxt_tap;
        tick_ff <= nxt_tick;
    end

    // Taps change only here, never from frequency reconfiguration
    assign fb_tap = tap_ff[0];

    // Counter k sits at bits 3k+2:3k
    genvar g;
    generate
        for (g = 0; g < pds_pkg::NUM_OUT; g++) begin : g_out
            assign out_tap[g*pds_pkg::TAP_W +: pds_pkg::TAP_W] = tap_ff[g+1];
        end
    endgenerate
    assign vco_tick = tick_ff;
endmodule // pds_device

/* hdl/pds_ctrl.sv */
// Controller end: makes scan_clk by dividing clk and runs the step handshake.
// Assumes the user holds sel and up stable while start is pending.
`timescale 1ns/1ns
module pds_ctrl (
    pds_if.ctl link,
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [pds_pkg::SEL_W-1:0] sel,
    input wire logic up,
    output logic busy,
    output logic step_ok
);
    pds_pkg::pds_ctl_state_t st_ff, nxt_st;
    logic [2:0] div_ff, nxt_div;
    logic sclk_ff, nxt_sclk;
    logic [1:0] done_sync_ff;
    logic req_ff, nxt_req;
    logic [pds_pkg::SEL_W-1:0] sel_ff, nxt_sel;
    logic up_ff, nxt_up;
    logic [1:0] hold_ff, nxt_hold;
    logic ok_ff, nxt_ok;
    logic rise;

    assign rise = (div_ff == pds_pkg::SCLK_HALF - 3'h1) && !sclk_ff;

    always_comb begin
        nxt_div = (div_ff == pds_pkg::SCLK_HALF - 3'h1) ? 3'h0 : div_ff + 3'h1;
        nxt_sclk = (div_ff == pds_pkg::SCLK_HALF - 3'h1) ? ~sclk_ff : sclk_ff;
        nxt_st = st_ff;
        nxt_req = req_ff;
        nxt_sel = sel_ff;
        nxt_up = up_ff;
        nxt_hold = hold_ff;
        nxt_ok = 1'b0;
        case (st_ff)
            pds_pkg::PDS_IDLE: begin
                if (start && done_sync_ff[1] && rise) begin
                    nxt_sel = sel;
                    nxt_up = up;
                    nxt_st = pds_pkg::PDS_WAIT;
                end
            end
            pds_pkg::PDS_WAIT: begin
                if (rise) begin
                    nxt_req = 1'b1;
                    nxt_hold = 2'h0;
                    nxt_st = pds_pkg::PDS_REL;
                end
            end
            pds_pkg::PDS_REL: begin
                if (rise && hold_ff != 2'h2) begin
                    nxt_hold = hold_ff + 2'h1;
                end
                // Three full scan cycles and done seen low before release
                if (rise && hold_ff == 2'h2 && !done_sync_ff[1]) begin
                    nxt_req = 1'b0;
                    nxt_st = pds_pkg::PDS_DONE;
                end
            end
            pds_pkg::PDS_DONE: begin
                if (done_sync_ff[1] && rise) begin
                    nxt_ok = 1'b1;
                    nxt_st = pds_pkg::PDS_IDLE;
                end
            end
            default: nxt_st = pds_pkg::PDS_IDLE;
        endcase
        if (srst) begin
            nxt_div = 3'h0;
            // Keep scan_clk toggling so the far end sees its reset edges
            if (sclk_ff) begin
                nxt_sclk = 1'b0;
            end else begin
                nxt_sclk = 1'b1;
            end
            nxt_st = pds_pkg::PDS_IDLE;
            nxt_req = 1'b0;
            nxt_sel = pds_pkg::SEL_ALL;
            nxt_up = 1'b0;
            nxt_hold = 2'h0;
            nxt_ok = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        div_ff <= nxt_div;
        sclk_ff <= nxt_sclk;
        st_ff <= nxt_st;
        req_ff <= nxt_req;
        sel_ff <= nxt_sel;
        up_ff <= nxt_up;
        hold_ff <= nxt_hold;
        ok_ff <= nxt_ok;
        done_sync_ff <= {done_sync_ff[0], link.step_done};
    end

    assign link.scan_clk = sclk_ff;
    assign link.step_req = req_ff;
    assign link.counter_sel = sel_ff;
    assign link.step_up = up_ff;
    assign busy = (st_ff != pds_pkg::PDS_IDLE);
    assign step_ok = ok_ff;
endmodule // pds_ctrl

/* testbench/pds_checker.sv */
// Checker for the phase-step link between controller and PLL phase circuit.
// Assumes scan_clk is derived from clk and srst is held across both domains.
`timescale 1ns/1ns
module pds_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic scan_clk,
    input wire logic [pds_pkg::SEL_W-1:0] counter_sel,
    input wire logic step_up,
    input wire logic step_req,
    input wire logic step_done
);
    // Request must last two scan samples
    a_req_min_two: assert property (@(posedge scan_clk) disable iff (srst)
        $rose(step_req) |=> step_req) else $error("request shorter than two scan cycles");
    // Req may rise mid scan cycle, so one cycle of slack
    a_done_falls: assert property (@(posedge scan_clk) disable iff (srst)
        $rose(step_req) |-> ##[2:3] !step_done) else $error("done did not fall");
    a_done_returns: assert property (@(posedge scan_clk) disable iff (srst)
        $fell(step_done) |-> ##[1:16] step_done) else $error("done stuck low");
    a_drop_after_low: assert property (@(posedge scan_clk) disable iff (srst)
        $fell(step_req) |-> !$past(step_done)) else $error("request dropped before done low");
    a_gap_one: assert property (@(posedge scan_clk) disable iff (srst)
        $fell(step_req) |=> !step_req) else $error("no low gap between requests");
    a_req_when_ready: assert property (@(posedge scan_clk) disable iff (srst)
        $rose(step_req) |-> step_done) else $error("request raised while done low");
    a_sel_steady: assert property (@(posedge scan_clk) disable iff (srst)
        step_req && $past(step_req) |-> $stable(counter_sel) && $stable(step_up))
        else $error("select or direction moved during request");
    a_idle_ready: assert property (@(posedge scan_clk) disable iff (srst)
        !step_req && step_done |=> step_done) else $error("done fell with no request");
    a_scan_running: assert property (@(posedge clk) disable iff (srst)
        scan_clk |-> ##[1:4] !scan_clk) else $error("scan clock stopped");
endmodule // pds_checker

/* testbench/pll_dynamic_phase_shift_tb.sv */
// Bench joining controller and phase circuit through the link interface.
// Assumes the controller divides clk into scan_clk; vco_clk stands for the VCO.
`timescale 1ns/1ns
module pll_dynamic_phase_shift_tb;
    logic clk = 1'b0;
    logic vco_clk = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic [2:0] sel = 3'h0;
    logic up = 1'b0;
    logic busy, step_ok;
    logic [2:0] fb_tap, m_fb;
    logic [14:0] out_tap, m_out;
    logic [5:0] vco_tick, tick_prev, tick_acc;
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;
    pds_if link_if ();
    pds_device i_pds_device (.link(link_if), .clk(vco_clk), .srst(srst), .fb_tap(fb_tap),
        .out_tap(out_tap), .vco_tick(vco_tick));
    pds_ctrl i_pds_ctrl (.link(link_if), .clk(clk), .srst(srst), .start(start), .sel(sel),
        .up(up), .busy(busy), .step_ok(step_ok));
    pds_checker i_pds_checker (.clk(clk), .srst(srst), .scan_clk(link_if.scan_clk),
        .counter_sel(link_if.counter_sel), .step_up(link_if.step_up),
        .step_req(link_if.step_req), .step_done(link_if.step_done));
    always #50 clk = ~clk;
    // Unrelated in phase to clk
    always #24 vco_clk = ~vco_clk;
    always @(posedge vco_clk) begin
        tick_prev <= vco_tick;
        if (busy === 1'b1) begin
            tick_acc <= tick_acc | (vco_tick ^ tick_prev);
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("counts: comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Generous ceiling: a step takes well under a hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic apply(input logic [2:0] s, input logic u);
        logic [2:0] d;
        d = u ? 3'h1 : 3'h7;
        if (s == pds_pkg::SEL_FB) m_fb = m_fb + d;
        for (int k = 0; k < 5; k++) begin
            if (s == pds_pkg::SEL_ALL || s == k + 2) m_out[3*k +: 3] = m_out[3*k +: 3] + d;
        end
    endtask
    task automatic do_step(input logic [2:0] s, input logic u);
        int k;
        k = 0;
        @(negedge clk);
        sel = s;
        up = u;
        start = 1'b1;
        while (step_ok !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        start = 1'b0;
        check({15'h0, step_ok}, 16'h0001);
        apply(s, u);
        check({13'h0, fb_tap}, {13'h0, m_fb});
        check({1'b0, out_tap}, {1'b0, m_out});
    endtask
    task automatic t_reset();
        check({14'h0, busy, link_if.step_done}, 16'h0001);
        check({13'h0, fb_tap}, 16'h0000);
        check({1'b0, out_tap}, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_codes();
        // Downward pass first, so taps wrap below zero
        for (int i = 0; i < 16; i++) begin
            do_step(i[2:0], i[3]);
        end
        $display("test codes done");
    endtask
    task automatic t_ticks();
        tick_acc = 6'h0;
        do_step(pds_pkg::SEL_ALL, 1'b1);
        check({10'h0, tick_acc}, 16'h003F);
        $display("test ticks done");
    endtask
    task automatic t_b2b();
        int k;
        int pulses;
        k = 0;
        pulses = 0;
        @(negedge clk);
        sel = pds_pkg::SEL_OUT4;
        up = 1'b0;
        start = 1'b1;
        while (pulses < 2 && k < 800) begin
            @(negedge clk);
            k++;
            if (step_ok === 1'b1) pulses++;
        end
        start = 1'b0;
        repeat (60) @(negedge clk) if (step_ok === 1'b1) pulses++;
        check(16'(pulses), 16'h0002);
        apply(pds_pkg::SEL_OUT4, 1'b0);
        apply(pds_pkg::SEL_OUT4, 1'b0);
        check({1'b0, out_tap}, {1'b0, m_out});
        check({15'h0, busy}, 16'h0000);
        $display("test back to back done");
    endtask
    initial begin
        m_fb = 3'h0;
        m_out = 15'h0;
        tick_acc = 6'h0;
        repeat (20) @(negedge clk);
        srst = 1'b0;
        repeat (4) @(negedge clk);
        t_reset();
        t_codes();
        t_ticks();
        t_b2b();
        close_out();
    end
endmodule // pll_dynamic_phase_shift_tb
